//--- verilog/lps_pkg.sv
// shared constants and types for the light and distance sensor target
package lps_pkg;
   // serial bus target address and register window
   localparam logic [6:0] I2C_ADDR = 7'h13;
   localparam logic [7:0] REG_BASE = 8'h80;
   localparam logic [7:0] REG_LAST = 8'h90;
   localparam int REG_COUNT = 17;
   // register indices (byte address minus base)
   localparam logic [4:0] IDX_CMD = 5'h00;
   localparam logic [4:0] IDX_ID = 5'h01;
   localparam logic [4:0] IDX_LIGHT_HI = 5'h05;
   localparam logic [4:0] IDX_LIGHT_LO = 5'h06;
   localparam logic [4:0] IDX_DIST_HI = 5'h07;
   localparam logic [4:0] IDX_DIST_LO = 5'h08;
   // command register field positions
   localparam int B_SELFTIMED = 0;
   localparam int B_DIST_EN = 1;
   localparam int B_LIGHT_EN = 2;
   localparam int B_DIST_SINGLE = 3;
   localparam int B_LIGHT_SINGLE = 4;
   localparam int B_DIST_RDY = 5;
   localparam int B_LIGHT_RDY = 6;
   localparam int B_LOCK = 7;
   // reset values; identity byte value is arbitrary
   localparam logic [7:0] ID_VALUE = 8'h5a;
   localparam logic [7:0] MEM_RESET = 8'h00;
   // timing: conversion time and periodic interval
   localparam int CLK_PERIOD_PS = 5000;
   localparam int CONV_TIME_NS = 1000;
   localparam int CONV_CYCLES = (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int PERIOD_OSC_CYCLES = 64;

   typedef struct packed {
      logic light_en;
      logic dist_en;
      logic selftimed;
   } lps_cmd_t;

   typedef struct packed {
      logic [15:0] light;
      logic [15:0] distance;
   } lps_sample_t;

   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK,
      ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
   } lps_i2c_state_t;
endpackage : lps_pkg

//--- verilog/lps_regmem.sv
// byte register storage with registered read data
`timescale 1ns/1ps
`default_nettype none
module lps_regmem import lps_pkg::*; #(
   parameter int DEPTH = REG_COUNT,
   parameter int AW = 5
)(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [7:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [7:0] rdata_q
);
   logic [7:0] mem_q [DEPTH];

   // refuse shapes the address cannot reach
   if (DEPTH < 2 || DEPTH > (1 << AW)) begin : g_bad_depth
      $error("lps_regmem depth does not fit the address width");
   end

   // storage, one byte per register
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= MEM_RESET;
         end
      end else if (we && int'(waddr) < DEPTH) begin
         mem_q[waddr] <= wdata;
      end
   end

   // registered read port
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_q <= MEM_RESET;
      end else if (int'(raddr) < DEPTH) begin
         rdata_q <= mem_q[raddr];
      end else begin
         rdata_q <= 8'h00;
      end
   end
endmodule : lps_regmem
`default_nettype wire

//--- verilog/lps_sensor_core.sv
// serial target interface and measurement command logic of the sensor
// What this block does
// - answer only to target address 13 hex
// - 26 hex writes, 27 hex reads
// - address byte lsb gives transfer direction
// - seventeen byte registers reachable over bus
// - registers decoded contiguously 80 to 90 hex
// - works at standard, fast, high-speed rates
// - light ready flag, cleared reading 5/6
// - distance ready flag, cleared reading 7/8
// - periodic distance measurement when enabled, self-timed
// - self-timed starts timer; needs a channel enable
// - interrupt pin is open drain only
// - both single-shot bits measure simultaneously
// - single-shot ignored while self-timed is set
`timescale 1ns/1ps
`default_nettype none
module lps_sensor_core import lps_pkg::*; #(
   parameter int CONV_CYC = CONV_CYCLES,
   parameter int PERIOD_CYC = PERIOD_OSC_CYCLES
)(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic osc_clk,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   output logic int_o,
   output logic int_oe,
   input wire lps_sample_t sample
);
   if (CONV_CYC < 1 || CONV_CYC > 65535 || PERIOD_CYC < 2 || PERIOD_CYC > 65535) begin : g_bad_time
      $error("lps_sensor_core timing counts out of range");
   end

   logic [1:0] scl_s_q, sda_s_q;
   logic scl_prev_q, sda_prev_q;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         scl_s_q <= 2'h3;
         sda_s_q <= 2'h3;
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else begin
         scl_s_q <= {scl_s_q[0], scl_i};
         sda_s_q <= {sda_s_q[0], sda_i};
         scl_prev_q <= scl_s_q[1];
         sda_prev_q <= sda_s_q[1];
      end
   end

   logic scl, sda, scl_rise, scl_fall, bus_start, bus_stop;
   assign scl = scl_s_q[1];
   assign sda = sda_s_q[1];
   assign scl_rise = scl & ~scl_prev_q;
   assign scl_fall = ~scl & scl_prev_q;
   assign bus_start = scl & scl_prev_q & sda_prev_q & ~sda;
   assign bus_stop = scl & scl_prev_q & ~sda_prev_q & sda;

   // true when a byte lies in the register window
   function automatic logic in_window(input logic [7:0] b);
      return (b >= REG_BASE) && (b <= REG_LAST);
   endfunction

   lps_i2c_state_t state_q;
   logic [3:0] bitcnt_q;
   logic [7:0] shift_q, tx_q, rd_byte, mem_rdata;
   logic [4:0] ptr_q, wr_idx_q, rd_idx_q;
   logic [7:0] wr_data_q;
   logic rw_q, host_ack_q, reg_wr_q, rd_evt_q;
   logic light_rdy_q, dist_rdy_q, busy_light_q, busy_dist_q;
   lps_cmd_t cmd_q;
   lps_sample_t result_q;

   // bus target state machine, strobes are one-cycle pulses
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= ST_IDLE;
         bitcnt_q <= 4'h0;
         shift_q <= 8'h00;
         tx_q <= 8'h00;
         ptr_q <= 5'h00;
         rw_q <= 1'b0;
         host_ack_q <= 1'b0;
         sda_oe <= 1'b0;
         reg_wr_q <= 1'b0;
         wr_idx_q <= 5'h00;
         wr_data_q <= 8'h00;
         rd_evt_q <= 1'b0;
         rd_idx_q <= 5'h00;
      end else begin
         reg_wr_q <= 1'b0;
         rd_evt_q <= 1'b0;
         if (bus_start) begin
            state_q <= ST_ADDR;
            bitcnt_q <= 4'h0;
            sda_oe <= 1'b0;
         end else if (bus_stop) begin
            state_q <= ST_IDLE;
            sda_oe <= 1'b0;
         end else if (scl_rise) begin
            unique case (state_q)
               ST_ADDR, ST_REG, ST_WDATA: begin
                  shift_q <= {shift_q[6:0], sda};
                  bitcnt_q <= bitcnt_q + 4'h1;
               end
               ST_RDATA_ACK: begin
                  host_ack_q <= ~sda;
                  if (!sda) begin
                     ptr_q <= ptr_q + 5'h01; // next byte prefetched before the fall
                  end
               end
               default: begin
               end
            endcase
         end else if (scl_fall) begin
            unique case (state_q)
               ST_ADDR: begin
                  if (bitcnt_q == 4'h8) begin
                     if (shift_q[7:1] == I2C_ADDR) begin
                        rw_q <= shift_q[0];
                        sda_oe <= 1'b1;
                        state_q <= ST_ADDR_ACK;
                     end else begin
                        state_q <= ST_IDLE;
                     end
                  end
               end
               ST_ADDR_ACK: begin
                  if (rw_q) begin
                     tx_q <= {rd_byte[6:0], 1'b0};
                     sda_oe <= ~rd_byte[7];
                     rd_evt_q <= 1'b1;
                     rd_idx_q <= ptr_q;
                     bitcnt_q <= 4'h1;
                     state_q <= ST_RDATA;
                  end else begin
                     sda_oe <= 1'b0;
                     bitcnt_q <= 4'h0;
                     state_q <= ST_REG;
                  end
               end
               ST_REG: begin
                  if (bitcnt_q == 4'h8) begin
                     if (in_window(shift_q)) begin
                        ptr_q <= 5'(shift_q - REG_BASE);
                        sda_oe <= 1'b1;
                        state_q <= ST_REG_ACK;
                     end else begin
                        state_q <= ST_IDLE;
                     end
                  end
               end
               ST_REG_ACK, ST_WDATA_ACK: begin
                  if (state_q == ST_WDATA_ACK) begin
                     ptr_q <= ptr_q + 5'h01;
                  end
                  sda_oe <= 1'b0;
                  bitcnt_q <= 4'h0;
                  state_q <= ST_WDATA;
               end
               ST_WDATA: begin
                  if (bitcnt_q == 4'h8) begin
                     reg_wr_q <= 1'b1;
                     wr_idx_q <= ptr_q;
                     wr_data_q <= shift_q;
                     sda_oe <= 1'b1;
                     state_q <= ST_WDATA_ACK;
                  end
               end
               ST_RDATA: begin
                  if (bitcnt_q == 4'h8) begin
                     sda_oe <= 1'b0;
                     state_q <= ST_RDATA_ACK;
                  end else begin
                     sda_oe <= ~tx_q[7];
                     tx_q <= {tx_q[6:0], 1'b0};
                     bitcnt_q <= bitcnt_q + 4'h1;
                  end
               end
               ST_RDATA_ACK: begin
                  if (host_ack_q) begin
                     tx_q <= {rd_byte[6:0], 1'b0};
                     sda_oe <= ~rd_byte[7];
                     rd_evt_q <= 1'b1;
                     rd_idx_q <= ptr_q;
                     bitcnt_q <= 4'h1;
                     state_q <= ST_RDATA;
                  end else begin
                     state_q <= ST_IDLE;
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end

   // parameter storage for the non-computed registers
   logic mem_we;
   assign mem_we = reg_wr_q && !(wr_idx_q == IDX_CMD || wr_idx_q == IDX_ID ||
                   (wr_idx_q >= IDX_LIGHT_HI && wr_idx_q <= IDX_DIST_LO));
   lps_regmem #(.DEPTH(REG_COUNT), .AW(5)) u_mem (
      .mclk(mclk),
      .reset_n(reset_n),
      .we(mem_we),
      .waddr(wr_idx_q),
      .wdata(wr_data_q),
      .raddr(ptr_q),
      .rdata_q(mem_rdata)
   );

   // read data selection by register index
   always_comb begin
      unique case (ptr_q)
         IDX_CMD: rd_byte = {1'b1, light_rdy_q, dist_rdy_q, busy_light_q, busy_dist_q,
                             cmd_q.light_en, cmd_q.dist_en, cmd_q.selftimed};
         IDX_ID: rd_byte = ID_VALUE;
         IDX_LIGHT_HI: rd_byte = result_q.light[15:8];
         IDX_LIGHT_LO: rd_byte = result_q.light[7:0];
         IDX_DIST_HI: rd_byte = result_q.distance[15:8];
         IDX_DIST_LO: rd_byte = result_q.distance[7:0];
         default: rd_byte = (int'(ptr_q) < REG_COUNT) ? mem_rdata : 8'h00;
      endcase
   end

   // command register enable bits
   logic cmd_wr;
   assign cmd_wr = reg_wr_q && wr_idx_q == IDX_CMD;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cmd_q <= '0;
      end else if (cmd_wr) begin
         cmd_q <= {wr_data_q[B_LIGHT_EN], wr_data_q[B_DIST_EN], wr_data_q[B_SELFTIMED]};
      end
   end

   // oscillator-domain interval timer, gated by synchronised enable
   logic [1:0] st_en_s_q;
   logic [15:0] per_cnt_q;
   logic tick_tog_q;
   always_ff @(posedge osc_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_en_s_q <= 2'h0;
         per_cnt_q <= 16'h0000;
         tick_tog_q <= 1'b0;
      end else begin
         st_en_s_q <= {st_en_s_q[0], cmd_q.selftimed};
         if (!st_en_s_q[1]) begin
            per_cnt_q <= 16'h0000;
         end else if (per_cnt_q == 16'(PERIOD_CYC - 1)) begin
            per_cnt_q <= 16'h0000;
            tick_tog_q <= ~tick_tog_q;
         end else begin
            per_cnt_q <= per_cnt_q + 16'h0001;
         end
      end
   end

   // interval event brought back to the bus clock
   logic [1:0] tick_s_q;
   logic tick_prev_q, per_pulse;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         tick_s_q <= 2'h0;
         tick_prev_q <= 1'b0;
      end else begin
         tick_s_q <= {tick_s_q[0], tick_tog_q};
         tick_prev_q <= tick_s_q[1];
      end
   end
   assign per_pulse = tick_s_q[1] ^ tick_prev_q;

   logic od_ok, req_light, req_dist, busy_any, conv_done;
   logic [15:0] conv_cnt_q;
   assign od_ok = cmd_wr && !cmd_q.selftimed && !wr_data_q[B_SELFTIMED];
   assign req_light = (od_ok && wr_data_q[B_LIGHT_SINGLE]) || (per_pulse && cmd_q.selftimed && cmd_q.light_en);
   assign req_dist = (od_ok && wr_data_q[B_DIST_SINGLE]) || (per_pulse && cmd_q.selftimed && cmd_q.dist_en);
   assign busy_any = busy_light_q | busy_dist_q;
   assign conv_done = busy_any && conv_cnt_q == 16'h0000;

   // conversion engine shared by both channels
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         busy_light_q <= 1'b0;
         busy_dist_q <= 1'b0;
         conv_cnt_q <= 16'h0000;
         result_q <= '0;
      end else if (!busy_any) begin
         if (req_light || req_dist) begin
            busy_light_q <= req_light;
            busy_dist_q <= req_dist;
            conv_cnt_q <= 16'(CONV_CYC - 1);
         end
      end else if (conv_done) begin
         if (busy_light_q) begin
            result_q.light <= sample.light;
         end
         if (busy_dist_q) begin
            result_q.distance <= sample.distance;
         end
         busy_light_q <= 1'b0;
         busy_dist_q <= 1'b0;
      end else begin
         conv_cnt_q <= conv_cnt_q - 16'h0001;
      end
   end

   // light ready flag, set wins over read clear
   // distance ready flag, set wins over read clear
   logic clr_light, clr_dist;
   assign clr_light = rd_evt_q && (rd_idx_q == IDX_LIGHT_HI || rd_idx_q == IDX_LIGHT_LO);
   assign clr_dist = rd_evt_q && (rd_idx_q == IDX_DIST_HI || rd_idx_q == IDX_DIST_LO);
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         light_rdy_q <= 1'b0;
         dist_rdy_q <= 1'b0;
      end else begin
         light_rdy_q <= (conv_done && busy_light_q) || (light_rdy_q && !clr_light);
         dist_rdy_q <= (conv_done && busy_dist_q) || (dist_rdy_q && !clr_dist);
      end
   end

   // open-drain pins: only ever pull low
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sda_o <= 1'b0;
         int_o <= 1'b0;
         int_oe <= 1'b0;
      end else begin
         sda_o <= 1'b0;
         int_o <= 1'b0;
         int_oe <= light_rdy_q | dist_rdy_q;
      end
   end

   // checks beside the logic
   sequence s_addr_done;
      state_q == ST_ADDR && scl_fall && !bus_start && !bus_stop && bitcnt_q == 4'h8;
   endsequence
   sequence s_both_single;
      cmd_wr && od_ok && wr_data_q[B_LIGHT_SINGLE] && wr_data_q[B_DIST_SINGLE] && !busy_any;
   endsequence

   a_addr_reject: assert property (@(posedge mclk) disable iff (!reset_n)
      s_addr_done and (shift_q[7:1] != I2C_ADDR) |=> state_q == ST_IDLE && !sda_oe)
      else $error("foreign address was acknowledged");
   a_dir_decode: assert property (@(posedge mclk) disable iff (!reset_n)
      s_addr_done and (shift_q[7:1] == I2C_ADDR) |=> rw_q == $past(shift_q[0]) && sda_oe)
      else $error("direction bit not taken from address byte");
   a_window_nack: assert property (@(posedge mclk) disable iff (!reset_n)
      (state_q == ST_REG && scl_fall && !bus_start && !bus_stop && bitcnt_q == 4'h8 && !in_window(shift_q))
      |=> !sda_oe && state_q == ST_IDLE)
      else $error("register byte outside window was acknowledged");
   a_light_clear: assert property (@(posedge mclk) disable iff (!reset_n)
      clr_light && !(conv_done && busy_light_q) |=> !light_rdy_q)
      else $error("light ready not cleared by result read");
   a_dist_set: assert property (@(posedge mclk) disable iff (!reset_n)
      conv_done && busy_dist_q |=> dist_rdy_q && !busy_any)
      else $error("distance ready not set at conversion end");
   a_both_start: assert property (@(posedge mclk) disable iff (!reset_n)
      s_both_single |=> busy_light_q && busy_dist_q && conv_cnt_q == 16'(CONV_CYC - 1))
      else $error("simultaneous single shot did not start both channels");
   a_single_refused: assert property (@(posedge mclk) disable iff (!reset_n)
      cmd_wr && cmd_q.selftimed && !per_pulse && !busy_any |=> !busy_any)
      else $error("single shot accepted while self-timed");
   a_periodic_light: assert property (@(posedge mclk) disable iff (!reset_n)
      per_pulse && cmd_q.selftimed && cmd_q.light_en && !busy_any |=> busy_light_q)
      else $error("periodic light measurement not started");
   a_no_channel: assert property (@(posedge mclk) disable iff (!reset_n)
      per_pulse && !cmd_wr && !(cmd_q.light_en || cmd_q.dist_en) && !busy_any |=> !busy_any)
      else $error("periodic measurement with no channel enabled");
   a_int_pull: assert property (@(posedge mclk) disable iff (!reset_n)
      light_rdy_q |=> int_oe && !int_o)
      else $error("interrupt pin not pulled low while data ready");
endmodule : lps_sensor_core
`default_nettype wire

//--- verif/lps_host.sv
// two-wire bus host model that drives the sensor's bus pins
`timescale 1ns/1ps
`default_nettype none
module lps_host (
   input wire logic mclk,
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   // quarter bit time in mclk cycles, about 3.3 MHz bus clock
   localparam int Q = 15;
   // bus idles released, both lines high
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // every pin change lands just after a clock edge
   task automatic tq;
      repeat (Q) @(posedge mclk);
      #1;
   endtask : tq
   // start or repeated start
   task automatic start;
      sda_low = 1'b0;
      tq();
      scl = 1'b1;
      tq();
      sda_low = 1'b1;
      tq();
      scl = 1'b0;
      tq();
   endtask : start
   task automatic stop;
      sda_low = 1'b1;
      tq();
      scl = 1'b1;
      tq();
      sda_low = 1'b0;
      tq();
   endtask : stop
   // one bit out, data stable while clock high
   task automatic sbit(input logic b);
      sda_low = ~b;
      tq();
      scl = 1'b1;
      tq();
      tq();
      scl = 1'b0;
      tq();
   endtask : sbit
   // one bit in with the data line released to its pull-up
   task automatic rbit(output logic b);
      sda_low = 1'b0;
      tq();
      scl = 1'b1;
      tq();
      b = sda;
      tq();
      scl = 1'b0;
      tq();
   endtask : rbit
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         sbit(b[i]);
      end
      rbit(r);
      ack = ~r;
   endtask : wbyte
   task automatic rbyte(input logic more, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) begin
         rbit(d[i]);
      end
      sbit(~more);
   endtask : rbyte
   task automatic wreg(input logic [7:0] dev, input logic [7:0] ra, input logic [7:0] d,
                       output logic [2:0] acks);
      acks = 3'h0;
      start();
      wbyte(dev, acks[0]);
      if (acks[0]) begin
         wbyte(ra, acks[1]);
      end
      if (acks[1]) begin
         wbyte(d, acks[2]);
      end
      stop();
   endtask : wreg
   // write address then read address after repeated start
   task automatic rreg(input logic [7:0] ra, output logic [15:0] d);
      logic a;
      start();
      wbyte(8'h26, a);
      wbyte(ra, a);
      start();
      wbyte(8'h27, a);
      rbyte(1'b1, d[15:8]);
      rbyte(1'b0, d[7:0]);
      stop();
   endtask : rreg
endmodule : lps_host
`default_nettype wire

//--- verif/tb.sv
// self-checking bench for the sensor bus target and command logic
`timescale 1ns/1ps
`default_nettype none
module tb import lps_pkg::*; ;
   logic mclk, reset_n, osc_clk, scl, sda_low, sda_o, sda_oe, int_o, int_oe;
   lps_sample_t sample;
   logic [2:0] acks;
   logic [15:0] rd;
   int failures, n_compared;
   // open-drain wires with pull-ups
   wire sda = ~(sda_low | sda_oe);
   wire int_n = ~int_oe;
   lps_sensor_core #(.CONV_CYC(4), .PERIOD_CYC(8)) u_dut (.mclk(mclk), .reset_n(reset_n),
      .osc_clk(osc_clk), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
      .int_o(int_o), .int_oe(int_oe), .sample(sample));
   lps_host u_host (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low));
   // clocks, oscillator phase unrelated to mclk
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   initial begin
      osc_clk = 1'b0;
      #13;
      forever #40 osc_clk = ~osc_clk;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_sim
   task automatic t_reset;
      u_host.rreg(8'h80, rd);
      check(rd, {8'h80, ID_VALUE});
      check(int_n, 1);
      check(sda_o, 1'b0);
      check(int_o, 1'b0);
      $display("test reset done");
   endtask : t_reset
   // wrong target address and register bytes at both window edges
   task automatic t_addr;
      u_host.wreg(8'h28, 8'h80, 8'h00, acks);
      check(acks, 3'h0);
      u_host.wreg(8'h26, 8'h91, 8'h00, acks);
      check(acks, 3'h1);
      u_host.wreg(8'h26, 8'h7f, 8'h00, acks);
      check(acks, 3'h1);
      u_host.wreg(8'h26, 8'h90, 8'ha5, acks);
      check(acks, 3'h7);
      u_host.rreg(8'h90, rd);
      check(rd, 16'ha500);
      $display("test address done");
   endtask : t_addr
   // both single shots at once, then flags cleared by result reads
   task automatic t_single;
      sample = {16'h1234, 16'h5678};
      u_host.wreg(8'h26, 8'h80, 8'h18, acks);
      check(acks, 3'h7);
      u_host.rreg(8'h80, rd);
      check(rd, {8'he0, ID_VALUE});
      check(int_n, 0);
      u_host.rreg(8'h85, rd);
      check(rd, 16'h1234);
      u_host.rreg(8'h80, rd);
      check(rd, {8'ha0, ID_VALUE});
      u_host.rreg(8'h87, rd);
      check(rd, 16'h5678);
      u_host.rreg(8'h80, rd);
      check(rd, {8'h80, ID_VALUE});
      check(int_n, 1);
      $display("test single done");
   endtask : t_single
   // self-timed mode alone, blocked single shots, then each periodic channel
   task automatic t_self;
      u_host.wreg(8'h26, 8'h80, 8'h01, acks);
      repeat (400) @(posedge mclk);
      u_host.wreg(8'h26, 8'h80, 8'h19, acks);
      repeat (400) @(posedge mclk);
      u_host.wreg(8'h26, 8'h80, 8'h00, acks);
      u_host.rreg(8'h80, rd);
      check(rd, {8'h80, ID_VALUE});
      sample = {16'hbeef, 16'h0f0f};
      u_host.wreg(8'h26, 8'h80, 8'h05, acks);
      repeat (400) @(posedge mclk);
      u_host.wreg(8'h26, 8'h80, 8'h04, acks);
      u_host.rreg(8'h80, rd);
      check(rd, {8'hc4, ID_VALUE});
      u_host.rreg(8'h85, rd);
      check(rd, 16'hbeef);
      u_host.wreg(8'h26, 8'h80, 8'h03, acks);
      repeat (400) @(posedge mclk);
      u_host.wreg(8'h26, 8'h80, 8'h02, acks);
      u_host.rreg(8'h80, rd);
      check(rd, {8'ha2, ID_VALUE});
      u_host.rreg(8'h87, rd);
      check(rd, 16'h0f0f);
      $display("test selftimed done");
   endtask : t_self
   // reset in mid-run clears flags, enables and plain storage
   task automatic t_rerun;
      u_host.wreg(8'h26, 8'h80, 8'h1c, acks);
      check(acks, 3'h7);
      check(int_n, 0);
      reset_n = 1'b0;
      repeat (4) @(posedge mclk);
      #1;
      reset_n = 1'b1;
      check(int_o, 1'b0);
      u_host.rreg(8'h80, rd);
      check(rd, {8'h80, ID_VALUE});
      check(int_n, 1);
      u_host.rreg(8'h90, rd);
      check(rd, 16'h0000);
      $display("test mid-run reset done");
   endtask : t_rerun
   // reset held four clocks; both domains clear asynchronously
   initial begin
      failures = 0;
      n_compared = 0;
      reset_n = 1'b0;
      sample = '0;
      repeat (4) @(posedge mclk);
      #1;
      reset_n = 1'b1;
      t_reset();
      t_addr();
      t_single();
      t_self();
      t_rerun();
      end_sim();
   end
   // watchdog well past the expected run of about 62000 cycles
   initial begin
      repeat (90000) @(posedge mclk);
      failures++;
      end_sim();
   end
endmodule : tb
`default_nettype wire
